// ==== common/guard_pkg.sv ====
// ==========================================================
// shared constants of the 24-bit watchdog
package guard_pkg;
  // ==========================================================
  // widths
  localparam int CNT_W = 24;   // down counter width
  localparam int REG_W = 8;    // each register holds one byte
  localparam int DATA_W = 32;  // axi4-lite data width

  // ==========================================================
  // register word indices, byte address is four times these
  localparam logic [11:0] IDX_CTL = 12'hff0;    // guard_control_reg
  localparam logic [11:0] IDX_UPPER = 12'hff1;  // reload_upper_byte
  localparam logic [11:0] IDX_HIGH = 12'hff2;   // reload_high_byte
  localparam logic [11:0] IDX_LOW = 12'hff3;    // reload_low_byte

  // ==========================================================
  // reset values of the reload bytes
  localparam logic [7:0] UPPER_RST = 8'h00;
  localparam logic [7:0] HIGH_RST = 8'h04;
  localparam logic [7:0] LOW_RST = 8'h00;

  // ==========================================================
  // unlock keys written to the control address
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // ==========================================================
  // counter landmarks
  localparam logic [23:0] CNT_MAX = 24'hffffff;   // wrap value
  localparam logic [23:0] CNT_FREEZE = 24'h000002; // no refresh at/below
  localparam logic [23:0] CNT_LAST = 24'h000001;  // next tick times out

  // ==========================================================
  // status byte layout, read at the control address
  localparam int STAT_TIMEOUT_BIT = 5;
  localparam int STAT_STOP_BIT = 4;
  localparam int STAT_RUN_BIT = 0;

  // ==========================================================
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // reload lock sequencer, gray along the unlock path
  typedef enum logic [2:0] {
    LK_IDLE = 3'h0,
    LK_KEY1 = 3'h1,
    LK_OPEN = 3'h3,
    LK_WANT_H = 3'h2,
    LK_WANT_L = 3'h6
  } lock_state_t;
endpackage

// ==== hdl/watchdog_timer_24bit.sv ====
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
// Contract
// - 24-bit down counter on rc oscillator
// - once on, counts forever, never off
// - always-on option starts counting after reset
// - reload is upper, high, low concatenated
// - refresh ignored once count reached two
// - first enable loads counter from reload
// - refresh reloads counter, counting resumes
// - debug mode keeps refreshing the counter
// - zero count times out, option picks response
// - interrupt mode raises request, sets flag
// - after interrupt time-out counter wraps all-ones
// - status read clears the time-out flag
// - stop interrupt mode recovers, requests, flags
// - reset mode forces system reset, sets flag
// - stop reset mode recovers instead, both flags
// - 55h then aah unlocks, control bits unchanged
// - reload bytes in order, else relock
// - reload reads return live count bytes
module watchdog_timer_24bit #(
  parameter int ADDR_W = 14  // axi byte address width
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,                    // freezes all state when low
  // oscillator and core side
  input wire logic osc_clk_in,            // rc oscillator, asynchronous
  input wire logic refresh_instruction,   // one-cycle pulse from cpu
  input wire logic always_on_option,      // option bit, static
  input wire logic timeout_response_option, // 1 reset, 0 interrupt
  input wire logic on_chip_debugger,      // debug mode level
  input wire logic stop_mode,             // core is in stop mode
  output logic irq_req,                   // request to irq controller
  output logic sys_reset_req,             // one-cycle reset pulse
  output logic stop_recovery,             // one-cycle recovery pulse
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [guard_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [guard_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import guard_pkg::*;

  // ==========================================================
  // elaboration checks
  if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 14 and 32");
  end

  // word index compare against a printed register index
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [11:0] idx);
    return a[ADDR_W-1:2] == (ADDR_W-2)'(idx);
  endfunction

  // ==========================================================
  // state declarations
  logic osc_s1_q, osc_s2_q, osc_s3_q; // oscillator synchroniser
  logic tick;                         // one rising osc edge seen
  logic en_q;                         // watchdog running
  logic ao_arm_q;                     // first cycle after reset
  logic [CNT_W-1:0] count_q;          // live down counter
  logic [7:0] upper_q, high_q, low_q; // stored reload bytes
  logic [CNT_W-1:0] reload_val;       // concatenated reload
  lock_state_t lock_q;                // unlock sequencer
  logic to_flag_q, stop_flag_q;       // sticky status bits
  logic irq_q, sys_reset_q, stop_rec_q;
  logic start_now, load_now, timeout_now;
  // write channel holding
  logic aw_full_q, w_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire, wr_ctl, wr_up, wr_hi, wr_lo, wr_map;
  // read channel
  logic rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic rd_fire, rd_ctl;

  // ==========================================================
  // oscillator crossing
  // two flops before anything looks at the rc clock; the third
  // flop only serves the edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else if (ce) begin
      osc_s1_q <= osc_clk_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign tick = osc_s2_q & ~osc_s3_q;

  // ==========================================================
  // counter control terms
  assign reload_val = {upper_q, high_q, low_q};
  assign start_now = refresh_instruction | (ao_arm_q & always_on_option);

  always_comb begin
    load_now = 1'b0;
    if (!en_q) begin
      load_now = start_now;
    end else if (on_chip_debugger) begin
      load_now = 1'b1;
    end else if (refresh_instruction && count_q > CNT_FREEZE) begin
      load_now = 1'b1;
    end
  end

  // zero is reached on the tick that leaves the last count
  assign timeout_now = ce & en_q & tick & ~load_now &
                       (count_q == CNT_LAST);

  // ==========================================================
  // always-on capture, taken on the first cycle after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ao_arm_q <= 1'b1;
    end else if (ce) begin
      ao_arm_q <= 1'b0;
    end
  end

  // ==========================================================
  // run state: nothing can clear it except reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= 1'b0;
    end else if (ce && start_now) begin
      en_q <= 1'b1;
    end
  end

  // ==========================================================
  // down counter
  // plain decrement wraps 0 to all-ones, so interrupt mode
  // rolls over instead of reloading
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
    end else if (ce) begin
      if (load_now) begin
        count_q <= reload_val;
      end else if (en_q && tick) begin
        count_q <= count_q - CNT_LAST;
      end
    end
  end

  // ==========================================================
  // time-out responses, one-cycle pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset_q <= 1'b0;
      stop_rec_q <= 1'b0;
    end else if (ce) begin
      // stop mode swaps the reset for a recovery
      sys_reset_q <= timeout_now & timeout_response_option &
                     ~stop_mode;
      stop_rec_q <= timeout_now & stop_mode;
    end
  end

  // ==========================================================
  // sticky status flags; a time-out beats a clearing read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_flag_q <= 1'b0;
      stop_flag_q <= 1'b0;
    end else if (ce) begin
      if (timeout_now) begin
        to_flag_q <= 1'b1;
      end else if (rd_ctl) begin
        to_flag_q <= 1'b0;
      end
      if (timeout_now && stop_mode) begin
        stop_flag_q <= 1'b1;
      end else if (rd_ctl) begin
        stop_flag_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // interrupt request level, dropped by the status read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      if (timeout_now && !timeout_response_option) begin
        irq_q <= 1'b1;
      end else if (rd_ctl) begin
        irq_q <= 1'b0;
      end
    end
  end

  assign irq_req = irq_q;
  assign sys_reset_req = sys_reset_q;
  assign stop_recovery = stop_rec_q;

  // ==========================================================
  // axi write channels, address and data taken in any order
  assign s_axi_awready = ce & ~aw_full_q;
  assign s_axi_wready = ce & ~w_full_q;
  assign wr_fire = ce & aw_full_q & w_full_q & ~bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wbyte_q <= '0;
      wlane_q <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // write decode
  assign wr_ctl = hit(awaddr_q, IDX_CTL);
  assign wr_up = hit(awaddr_q, IDX_UPPER);
  assign wr_hi = hit(awaddr_q, IDX_HIGH);
  assign wr_lo = hit(awaddr_q, IDX_LOW);
  assign wr_map = wr_ctl | wr_up | wr_hi | wr_lo;

  // write response, unmapped answers slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ==========================================================
  // unlock sequencer
  // every write counts as a step; a write without lane 0 is a
  // wrong step, so it relocks too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q <= LK_IDLE;
    end else if (wr_fire) begin
      lock_q <= LK_IDLE;
      unique case (lock_q)
        LK_IDLE: begin
          if (wr_ctl && wlane_q && wbyte_q == KEY_FIRST) begin
            lock_q <= LK_KEY1;
          end
        end
        LK_KEY1: begin
          if (wr_ctl && wlane_q && wbyte_q == KEY_SECOND) begin
            lock_q <= LK_OPEN;
          end
        end
        LK_OPEN: begin
          if (wr_up && wlane_q) begin
            lock_q <= LK_WANT_H;
          end
        end
        LK_WANT_H: begin
          if (wr_hi && wlane_q) begin
            lock_q <= LK_WANT_L;
          end
        end
        LK_WANT_L: begin
          lock_q <= LK_IDLE;
        end
        default: begin
          lock_q <= LK_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // reload bytes, only accepted at their turn in the sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_q <= UPPER_RST;
      high_q <= HIGH_RST;
      low_q <= LOW_RST;
    end else if (wr_fire && wlane_q) begin
      if (lock_q == LK_OPEN && wr_up) begin
        upper_q <= wbyte_q;
      end
      if (lock_q == LK_WANT_H && wr_hi) begin
        high_q <= wbyte_q;
      end
      if (lock_q == LK_WANT_L && wr_lo) begin
        low_q <= wbyte_q;
      end
    end
  end

  // ==========================================================
  // axi read channel, one read under way at a time
  assign s_axi_arready = ce & ~rvalid_q;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_ctl = rd_fire & hit(s_axi_araddr, IDX_CTL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rresp_q <= RESP_OKAY;
        rdata_q <= '0;
        // reload addresses show the live count bytes
        if (rd_ctl) begin
          rdata_q[STAT_TIMEOUT_BIT] <= to_flag_q;
          rdata_q[STAT_STOP_BIT] <= stop_flag_q;
          rdata_q[STAT_RUN_BIT] <= en_q;
        end else if (hit(s_axi_araddr, IDX_UPPER)) begin
          rdata_q[7:0] <= count_q[23:16];
        end else if (hit(s_axi_araddr, IDX_HIGH)) begin
          rdata_q[7:0] <= count_q[15:8];
        end else if (hit(s_axi_araddr, IDX_LOW)) begin
          rdata_q[7:0] <= count_q[7:0];
        end else begin
          rresp_q <= RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ==========================================================
  // assertions
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  never_disabled_a: assert property ($fell(en_q) |-> 1'b0)
    else $error("watchdog left the running state");

  ao_start_a: assert property (
    $rose(aresetn) && ce && always_on_option |=> en_q)
    else $error("always-on option did not start the watchdog");

  first_load_a: assert property (
    !en_q && ce && refresh_instruction |=>
      en_q && count_q == $past(reload_val))
    else $error("first enable did not load the reload value");

  refresh_blocked_a: assert property (
    ce && en_q && !on_chip_debugger && refresh_instruction &&
    !tick && count_q <= CNT_FREEZE |=> $stable(count_q))
    else $error("refresh accepted at or below two");

  refresh_load_a: assert property (
    ce && en_q && refresh_instruction && count_q > CNT_FREEZE
    |=> count_q == $past(reload_val))
    else $error("refresh did not reload the counter");

  debug_hold_a: assert property (
    ce && en_q && on_chip_debugger |=> !sys_reset_q && !stop_rec_q
      ##0 count_q == $past(reload_val))
    else $error("debug mode let the counter run");

  wrap_max_a: assert property (
    ce && en_q && tick && !load_now && count_q == '0
    |=> count_q == CNT_MAX)
    else $error("counter did not wrap to all ones");

  irq_flag_a: assert property (
    timeout_now && !timeout_response_option |=>
      irq_req && to_flag_q && !sys_reset_req)
    else $error("interrupt time-out missed request or flag");

  read_clear_a: assert property (
    rd_ctl && !timeout_now |=> !to_flag_q && !irq_req)
    else $error("status read left the time-out flag set");

  reset_pulse_a: assert property (
    timeout_now && timeout_response_option && !stop_mode
    |=> sys_reset_req && to_flag_q ##1 !sys_reset_req)
    else $error("reset time-out did not pulse system reset");

  stop_recover_a: assert property (
    timeout_now && stop_mode |=>
      stop_recovery && stop_flag_q && to_flag_q && !sys_reset_req)
    else $error("stop time-out did not start recovery");

  lock_break_a: assert property (
    wr_fire && ((lock_q == LK_OPEN && !wr_up) ||
    (lock_q == LK_WANT_H && !wr_hi)) |=> lock_q == LK_IDLE)
    else $error("wrong step did not relock the reload bytes");

  key_pass_a: assert property (
    wr_fire && lock_q == LK_KEY1 && wr_ctl && wlane_q &&
    wbyte_q == KEY_SECOND |=> lock_q == LK_OPEN && $stable(to_flag_q))
    else $error("second key did not unlock");

  relock_low_a: assert property (
    wr_fire && lock_q == LK_WANT_L |=> lock_q == LK_IDLE)
    else $error("sequencer stayed open after the low byte");

  live_read_a: assert property (
    rd_fire && hit(s_axi_araddr, IDX_LOW) |=>
      s_axi_rdata[7:0] == $past(count_q[7:0]))
    else $error("low byte read did not show the live count");
endmodule

// ==== testbench/core_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// far side: rc oscillator plus core event monitor
module core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [7:0] n_tick,
  input wire logic sys_reset_req,
  input wire logic stop_recovery,
  output logic osc_clk_in,
  output logic busy,
  output int n_rst,
  output int n_rec
);
  logic [7:0] left_q; // ticks still to make
  logic [2:0] ph_q; // phase inside one tick
  // burst of ticks, 4 low then 4 high each, slower than aclk/2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_q <= 8'h00;
      ph_q <= 3'h0;
    end else if (go) begin
      left_q <= n_tick;
      ph_q <= 3'h0;
    end else if (left_q != 8'h00) begin
      ph_q <= ph_q + 3'h1;
      if (ph_q == 3'h7) left_q <= left_q - 8'h01;
    end
  end
  // held low between bursts so the count stays still for reads
  always_ff @(posedge aclk) begin
    osc_clk_in <= aresetn & ph_q[2] & (left_q != 8'h00);
  end
  assign busy = (left_q != 8'h00);
  // count reset and recovery pulses seen by the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_rst <= 0;
      n_rec <= 0;
    end else begin
      if (sys_reset_req) n_rst <= n_rst + 1;
      if (stop_recovery) n_rec <= n_rec + 1;
    end
  end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
// ==========================================================
// bench for the 24-bit watchdog
module tb;
  import guard_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1, rfr = 0, ao = 0;
  logic tro = 0, dbg = 0, stp = 0, go = 0;
  logic [7:0] n_tick = 0;
  logic osc, busy, irq_req, sys_reset_req, stop_recovery;
  logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_rst, n_rec, checks = 0, n_mismatch = 0;
  // byte addresses of the four words
  localparam logic [13:0] A_C = 14'h3fc0, A_U = 14'h3fc4;
  localparam logic [13:0] A_H = 14'h3fc8, A_L = 14'h3fcc;

  initial begin
    forever #4 aclk = ~aclk;
  end

  watchdog_timer_24bit watchdog_timer_24bit_inst (
    .aclk, .aresetn, .ce, .osc_clk_in(osc), .refresh_instruction(rfr),
    .always_on_option(ao), .timeout_response_option(tro),
    .on_chip_debugger(dbg), .stop_mode(stp), .irq_req, .sys_reset_req,
    .stop_recovery, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  core_model core_model_inst (
    .aclk, .aresetn, .go, .n_tick, .sys_reset_req, .stop_recovery,
    .osc_clk_in(osc), .busy, .n_rst, .n_rec
  );

  // ==========================================================
  // report and end
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic hang;
    n_mismatch++;
    finish_test();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // axi4-lite write, both channels offered together
  task automatic wr(input logic [13:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    logic ap, dp, ta, td, got;
    logic [1:0] r;
    int i;
    ap = 1;
    dp = 1;
    got = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (i = 0; i < 64 && (ap || dp); i++) begin
      @(negedge aclk);
      ta = ap && s_axi_awready === 1'b1;
      td = dp && s_axi_wready === 1'b1;
      @(posedge aclk);
      if (ta) begin
        s_axi_awvalid <= 0;
        ap = 0;
      end
      if (td) begin
        s_axi_wvalid <= 0;
        dp = 0;
      end
    end
    s_axi_bready <= 1;
    for (i = 0; i < 64 && !got && !(ap || dp); i++) begin
      @(negedge aclk);
      got = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge aclk);
    end
    s_axi_bready <= 0;
    if (!got) hang();
    else chk(r, er);
  endtask

  // axi4-lite read, data and response compared
  task automatic rd(input logic [13:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic got;
    logic [31:0] d;
    logic [1:0] r;
    int i;
    got = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (i = 0; i < 64 && !got; i++) begin
      @(negedge aclk);
      got = s_axi_arready === 1'b1;
      @(posedge aclk);
    end
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    for (i = 0; i < 64 && got; i++) begin
      @(negedge aclk);
      got = s_axi_rvalid !== 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end
    s_axi_rready <= 0;
    if (got || i == 0) hang();
    else begin
      chk(d, ed);
      chk({30'h0, r}, {30'h0, er});
    end
  endtask

  // ==========================================================
  // core side helpers
  task automatic refresh;
    @(posedge aclk);
    rfr <= 1;
    @(posedge aclk);
    rfr <= 0;
  endtask

  // n oscillator ticks, then room for sync and flag latency
  task automatic tick(input logic [7:0] n);
    logic done;
    int i;
    done = 0;
    @(posedge aclk);
    go <= 1;
    n_tick <= n;
    @(posedge aclk);
    go <= 0;
    for (i = 0; i < 4000 && !done; i++) begin
      @(negedge aclk);
      done = busy === 1'b0;
    end
    if (!done) hang();
    else repeat (8) @(posedge aclk);
  endtask

  // unlock then the three bytes in order
  task automatic prog(input logic [7:0] u, h, l);
    wr(A_C, KEY_FIRST, RESP_OKAY);
    wr(A_C, KEY_SECOND, RESP_OKAY);
    wr(A_U, u, RESP_OKAY);
    wr(A_H, h, RESP_OKAY);
    wr(A_L, l, RESP_OKAY);
  endtask

  // wrap off zero if needed, reload 6, run to time-out
  task automatic to_zero;
    tick(1);
    refresh();
    tick(6);
  endtask

  // ==========================================================
  // scenarios
  task automatic s_reset;
    rd(A_U, 0, RESP_OKAY);
    rd(A_L, 0, RESP_OKAY);
    rd(A_C, 0, RESP_OKAY);
    rd(14'h0100, 0, RESP_SLVERR);
    wr(14'h0100, 8'h11, RESP_SLVERR);
  endtask

  task automatic s_count;
    prog(8'h00, 8'h00, 8'h06);
    rd(A_C, 0, RESP_OKAY);
    refresh();
    rd(A_L, 6, RESP_OKAY);
    rd(A_C, 1, RESP_OKAY);
    tick(3);
    rd(A_L, 3, RESP_OKAY);
    refresh();
    rd(A_L, 6, RESP_OKAY);
    tick(4);
    refresh();
    rd(A_L, 2, RESP_OKAY);
    tick(2);
    chk(irq_req, 1);
    wr(A_C, KEY_FIRST, RESP_OKAY);
    rd(A_C, 32'h21, RESP_OKAY);
    chk(irq_req, 0);
    rd(A_C, 1, RESP_OKAY);
    tick(1);
    rd(A_U, 8'hff, RESP_OKAY);
    rd(A_L, 8'hff, RESP_OKAY);
  endtask

  task automatic s_lock;
    // drop the half-open key left over from s_count
    wr(A_C, 8'h00, RESP_OKAY);
    wr(A_C, KEY_FIRST, RESP_OKAY);
    wr(A_C, KEY_SECOND, RESP_OKAY);
    wr(A_U, 8'h01, RESP_OKAY);
    wr(A_C, 8'h00, RESP_OKAY);
    wr(A_H, 8'h05, RESP_OKAY);
    wr(A_L, 8'h09, RESP_OKAY);
    refresh();
    rd(A_L, 6, RESP_OKAY);
    rd(A_U, 1, RESP_OKAY);
    rd(A_H, 0, RESP_OKAY);
    prog(8'h01, 8'h02, 8'h03);
    refresh();
    rd(A_U, 1, RESP_OKAY);
    rd(A_H, 2, RESP_OKAY);
    rd(A_L, 3, RESP_OKAY);
    wr(A_L, 8'h09, RESP_OKAY);
    refresh();
    rd(A_L, 3, RESP_OKAY);
    prog(8'h00, 8'h00, 8'h06);
    refresh();
    // a write without lane 0 stores nothing and relocks
    wr(A_C, KEY_FIRST, RESP_OKAY);
    wr(A_C, KEY_SECOND, RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    wr(A_U, 8'h01, RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    wr(A_H, 8'h01, RESP_OKAY);
    refresh();
    rd(A_U, 0, RESP_OKAY);
    rd(A_H, 0, RESP_OKAY);
  endtask

  task automatic s_debug;
    @(posedge aclk);
    dbg <= 1;
    tick(3);
    rd(A_L, 6, RESP_OKAY);
    @(posedge aclk);
    dbg <= 0;
    // clock enable low: oscillator ticks must not move the count
    ce <= 0;
    tick(2);
    ce <= 1;
    rd(A_L, 6, RESP_OKAY);
  endtask

  task automatic s_modes;
    @(posedge aclk);
    tro <= 1;
    to_zero();
    chk(n_rst, 1);
    chk(irq_req, 0);
    rd(A_C, 32'h21, RESP_OKAY);
    @(posedge aclk);
    stp <= 1;
    to_zero();
    chk(n_rst, 1);
    chk(n_rec, 1);
    rd(A_C, 32'h31, RESP_OKAY);
    @(posedge aclk);
    tro <= 0;
    to_zero();
    chk(n_rec, 2);
    chk(irq_req, 1);
    rd(A_C, 32'h31, RESP_OKAY);
    @(posedge aclk);
    stp <= 0;
  endtask

  // second reset with the always-on option set
  task automatic s_always_on;
    @(posedge aclk);
    ao <= 1;
    aresetn <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd(A_H, 8'h04, RESP_OKAY);
    rd(A_C, 1, RESP_OKAY);
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    s_reset();
    s_count();
    s_lock();
    s_debug();
    s_modes();
    s_always_on();
    finish_test();
  end
endmodule
